// ===== logic/dsts_top.v
// Host port, indirect transfers, self test and data RAM test for the
// four-channel downconverter. Assumes the host keeps the documented
// sequences and that the datapath answers the external read strobe.
`timescale 1ns/1ps
`include "dsts_defs.vh"

module dsts_top #(
  parameter BUILT_IN_SELF_TEST_CLKS = 4096,   // Clocks per self-test phase
  parameter RAM_AW    = 13,     // Channel (2) plus offset (11)
  parameter REVISION  = 4'h5    // Arbitrary revision value
) (
  input  wire        i_mclk,
  input  wire        i_sys_rst,
  input  wire        i_ce_n,
  input  wire        i_wr_n,
  input  wire        i_rd_n,
  input  wire [2:0]  i_add,
  input  wire [15:0] i_p,
  output reg  [15:0] o_p,
  output reg         o_p_oe_n,
  input  wire        i_external_sync_input,
  output reg         o_iw_strobe,
  output reg  [15:0] o_iw_addr,
  output reg  [31:0] o_iw_data,
  output reg         o_ir_strobe,
  output reg  [15:0] o_ir_addr,
  input  wire [31:0] i_ir_data,
  output wire [3:0]  o_compute_hold,
  output wire [3:0]  o_engine_reset,
  output reg  [3:0]  o_chan_sw_reset,
  output reg         o_sync_pulse_output,
  output reg         o_int_sync,
  output wire        o_built_in_self_test_active,
  output wire [15:0] o_pn_data,
  input  wire        i_out_valid,
  input  wire [15:0] i_out_data,
  output wire        o_ram_test
);

  localparam RAM_DEPTH = 1 << RAM_AW;

  // Read sequencer states, one-hot
  localparam RS_IDLE = 3'b001;
  localparam RS_RAM  = 3'b010;
  localparam RS_EXT  = 3'b100;

  // Pin synchronisers, two stages each
  reg  [22:0] pin_s1;
  reg  [22:0] pin_s2;
  reg         wr_n_d;
  wire        ce_n_s;
  wire        wr_n_s;
  wire        rd_n_s;
  wire [2:0]  add_s;
  wire [15:0] p_s;
  wire        sync_in_s;

  // Write capture
  reg  [2:0]  wr_add_lat;
  reg  [15:0] wr_p_lat;
  reg         wr_ce_lat;
  wire        wr_done;

  // Register state
  reg  [31:0] hold_reg;
  reg  [31:0] rd_hold;
  reg  [31:0] ctrl;
  reg  [15:0] exp_sig;
  reg  [15:0] got_sig;
  reg         exp_given;
  reg         match;
  reg         phase_two;
  reg  [12:0] built_in_self_test_cnt;
  reg  [3:0]  hold_bits;
  reg  [3:0]  xfer_cnt;
  reg  [2:0]  rd_state;
  reg  [2:0]  next_rd_state;
  reg  [15:0] rd_addr;
  wire [23:0] ram_q;
  reg  [23:0] dram [0:RAM_DEPTH-1];

  // Indirect write decode
  reg         iw_go;
  reg  [15:0] iw_addr;
  wire        iw_chan;
  wire        iw_ram;
  wire        rd_ram;
  wire        rd_local;
  wire        built_in_self_test_start;
  wire        built_in_self_test_end;
  wire [15:0] sig_now;
  reg  [15:0] status;
  reg  [15:0] next_p;

  assign ce_n_s    = pin_s2[22];
  assign wr_n_s    = pin_s2[21];
  assign rd_n_s    = pin_s2[20];
  assign add_s     = pin_s2[19:17];
  assign p_s       = pin_s2[16:1];
  assign sync_in_s = pin_s2[0];

  // All host pins cross into the clock domain here
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_s1 <= 23'h700000;
      pin_s2 <= 23'h700000;
      wr_n_d <= 1'b1;
    end else begin
      pin_s1 <= {i_ce_n, i_wr_n, i_rd_n, i_add, i_p, i_external_sync_input};
      pin_s2 <= pin_s1;
      wr_n_d <= wr_n_s;
    end
  end

  // Sample address and data while the write strobe is low, hold them once it rises
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_add_lat <= 3'h0;
      wr_p_lat   <= 16'h0000;
      wr_ce_lat  <= 1'b0;
    end else if (!wr_n_s) begin
      wr_add_lat <= add_s;
      wr_p_lat   <= p_s;
      wr_ce_lat  <= !ce_n_s;
    end
  end

  // A write completes on the rising edge of the strobe
  assign wr_done = wr_n_s && !wr_n_d && wr_ce_lat;

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_reg <= 32'h0000_0000;
    end else if (wr_done && wr_add_lat == `DSTS_LOC_LOW) begin
      hold_reg[15:0] <= wr_p_lat;
    end else if (wr_done && wr_add_lat == `DSTS_LOC_HIGH) begin
      hold_reg[31:16] <= wr_p_lat;
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      iw_go   <= 1'b0;
      iw_addr <= 16'h0000;
    end else begin
      iw_go <= wr_done && wr_add_lat == `DSTS_LOC_WTARGET;
      if (wr_done && wr_add_lat == `DSTS_LOC_WTARGET) begin
        iw_addr <= wr_p_lat;
      end
    end
  end

  // channel digit, Q even, I odd
  assign iw_chan = iw_addr[15:14] == 2'b00;
  assign iw_ram  = o_ram_test && iw_chan && !iw_addr[11] && iw_addr[9:8] != 2'b11;
  assign rd_ram  = o_ram_test && rd_addr[15:14] == 2'b00 && !rd_addr[11] && rd_addr[9:8] != 2'b11;
  assign rd_local = rd_ram || rd_addr == `DSTS_GWA_CTRL || rd_addr == `DSTS_GWA_SIG;

  // Transfers not handled locally go to the datapath as one strobe
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_iw_strobe <= 1'b0;
      o_iw_addr   <= 16'h0000;
      o_iw_data   <= 32'h0000_0000;
    end else begin
      o_iw_strobe <= iw_go && !iw_ram && iw_addr != `DSTS_GWA_CTRL && iw_addr != `DSTS_GWA_SIG;
      if (iw_go) begin
        o_iw_addr <= iw_addr;
        o_iw_data <= hold_reg;
      end
    end
  end

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      xfer_cnt <= 4'h0;
    end else if (iw_go || (wr_done && wr_add_lat == `DSTS_LOC_RSELECT)) begin
      xfer_cnt <= 4'd`DSTS_XFER_CLKS - 4'd2;
    end else if (xfer_cnt != 4'h0) begin
      xfer_cnt <= xfer_cnt - 4'h1;
    end
  end

  // data RAM reachable in test mode
  // Index is channel (13:12) over offset (10:0); bit 11 is never stored
  always @(posedge i_mclk) begin
    if (iw_go && iw_ram) begin
      dram[{iw_addr[13:12], iw_addr[10:0]}] <= hold_reg[23:0];
    end
  end

  // Unregistered read, so the sequencer sees the address it just loaded
  assign ram_q = dram[{rd_addr[13:12], rd_addr[10:0]}];

  // Compute hold bits per channel
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_bits <= 4'h0;
    end else if (iw_go && iw_chan && !iw_ram && iw_addr[11:0] == `DSTS_CH_ENGINE) begin
      hold_bits[iw_addr[13:12]] <= hold_reg[`DSTS_HOLD_BIT];
    end
  end

  assign o_compute_hold = hold_bits;

  // Engine reset counter for each channel
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_eng
      reg       hold_d;
      reg [5:0] rst_cnt;
      always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
          hold_d  <= 1'b0;
          rst_cnt <= 6'h00;
        end else begin
          hold_d <= hold_bits[ch];
          if (hold_d && !hold_bits[ch]) begin
            rst_cnt <= 6'd`DSTS_ENG_RST_CLKS;
          end else if (rst_cnt != 6'h00) begin
            rst_cnt <= rst_cnt - 6'h01;
          end
        end
      end
      assign o_engine_reset[ch] = rst_cnt != 6'h00;
    end
  endgenerate

  // Channel software resets and sync pulses
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_chan_sw_reset     <= 4'h0;
      o_sync_pulse_output <= 1'b0;
      o_int_sync          <= 1'b0;
    end else begin
      o_chan_sw_reset <= 4'h0;
      if (iw_go && iw_chan && !iw_ram && iw_addr[11:0] == `DSTS_CH_SWRST) begin
        o_chan_sw_reset[iw_addr[13:12]] <= 1'b1;
      end
      if (iw_go && iw_addr == `DSTS_GWA_RST_ALL && hold_reg == 32'h0000_0000) begin
        o_chan_sw_reset <= 4'hF;
      end
      o_sync_pulse_output <= iw_go && (iw_addr == `DSTS_GWA_SYNC_BOTH || iw_addr == `DSTS_GWA_SYNC_OUT);
      o_int_sync          <= iw_go && iw_addr == `DSTS_GWA_SYNC_BOTH;
    end
  end

  assign built_in_self_test_start = iw_go && iw_addr == `DSTS_GWA_CTRL && hold_reg[`DSTS_START_BIT] && !ctrl[`DSTS_START_BIT];
  assign built_in_self_test_end   = ctrl[`DSTS_START_BIT] && built_in_self_test_cnt == 13'h0001;

  // Control register; start bit runs the phase
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl     <= `DSTS_CTRL_RST;
      built_in_self_test_cnt <= 13'h0000;
    end else begin
      if (iw_go && iw_addr == `DSTS_GWA_CTRL) begin
        ctrl <= hold_reg;
        if (built_in_self_test_start) begin
          built_in_self_test_cnt <= BUILT_IN_SELF_TEST_CLKS[12:0];
        end else begin
          ctrl[`DSTS_START_BIT] <= ctrl[`DSTS_START_BIT];
        end
      end else if (built_in_self_test_end) begin
        ctrl[`DSTS_START_BIT] <= 1'b0;
        built_in_self_test_cnt <= 13'h0000;
      end else if (ctrl[`DSTS_START_BIT]) begin
        built_in_self_test_cnt <= built_in_self_test_cnt - 13'h0001;
      end
    end
  end

  assign o_ram_test    = ctrl[`DSTS_RAMTEST_BIT];
  assign o_built_in_self_test_active = ctrl[`DSTS_START_BIT];

  dsts_sig_gen #(
    .WIDTH   (16)
  ) u_sig (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (built_in_self_test_start && !phase_two),
    .i_run     (o_built_in_self_test_active),
    .i_valid   (i_out_valid),
    .i_data    (i_out_data),
    .o_pn      (o_pn_data),
    .o_sig     (sig_now)
  );

  // Signature, phase tracking and comparison
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      exp_sig   <= `DSTS_SIG_RST;
      exp_given <= 1'b0;
      got_sig   <= `DSTS_SIG_RST;
      phase_two <= 1'b0;
      match     <= 1'b0;
    end else begin
      if (iw_go && iw_addr == `DSTS_GWA_SIG) begin
        exp_sig   <= hold_reg[15:0];
        exp_given <= 1'b1;
      end
      if (built_in_self_test_start) begin
        match <= 1'b0;
      end
      if (built_in_self_test_end) begin
        got_sig   <= sig_now;
        phase_two <= !phase_two;
        if (phase_two) begin
          match <= exp_given && sig_now == exp_sig;
        end
      end
    end
  end

  always @* begin
    next_rd_state = rd_state;
    case (rd_state)
      RS_IDLE: begin
        if (wr_done && wr_add_lat == `DSTS_LOC_RSELECT) begin
          next_rd_state = RS_RAM;
        end
      end
      RS_RAM: begin
        next_rd_state = rd_local ? RS_IDLE : RS_EXT;
      end
      RS_EXT: begin
        if (xfer_cnt == 4'h0) begin
          next_rd_state = RS_IDLE;
        end
      end
      default: begin
        next_rd_state = RS_IDLE;
      end
    endcase
  end

  // Read holding register loads from the selected source
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_state    <= RS_IDLE;
      rd_addr     <= 16'h0000;
      rd_hold     <= 32'h0000_0000;
      o_ir_strobe <= 1'b0;
      o_ir_addr   <= 16'h0000;
    end else begin
      rd_state    <= next_rd_state;
      o_ir_strobe <= 1'b0;
      if (rd_state == RS_IDLE && next_rd_state == RS_RAM) begin
        rd_addr <= wr_p_lat;
      end
      if (rd_state == RS_RAM) begin
        if (rd_ram) begin
          rd_hold <= {8'h00, ram_q};
        end else if (rd_addr == `DSTS_GWA_CTRL) begin
          rd_hold <= ctrl;
        end else if (rd_addr == `DSTS_GWA_SIG) begin
          rd_hold <= {got_sig, exp_sig};
        end else begin
          o_ir_strobe <= 1'b1;
          o_ir_addr   <= rd_addr;
        end
      end
      if (rd_state == RS_EXT && xfer_cnt == 4'h0) begin
        rd_hold <= i_ir_data;
      end
    end
  end

  // Direct status word
  always @* begin
    status = 16'h0000;
    status[`DSTS_MATCH_BIT]   = match;
    status[`DSTS_SYNCIN_BIT]  = sync_in_s;
    status[5:2]               = REVISION;
  end

  // Direct read multiplexer
  always @* begin
    case (add_s)
      `DSTS_LOC_LOW:     next_p = rd_hold[15:0];
      `DSTS_LOC_HIGH:    next_p = rd_hold[31:16];
      `DSTS_LOC_RSELECT: next_p = status;
      default:           next_p = 16'h0000;
    endcase
  end

  // Bus drive; enable is low while the device drives
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_p      <= 16'h0000;
      o_p_oe_n <= 1'b1;
    end else begin
      o_p      <= next_p;
      o_p_oe_n <= ce_n_s || rd_n_s;
    end
  end

endmodule // dsts_top

// ===== inc/dsts_defs.vh
// Contract
// - Hold release starts 32-clock engine reset.
// - F80A syncs output and input; F809 output only.
// - Channel offset 019 write resets that channel. With F800 bit 15 set, the code writes it to data RAM and resets nothing.
// - Self test feeds pseudo-random input, builds signature.
// - F80B: expected low half, computed high half.
// - Zero write to F019 resets all channels.
// - Writing one to F800 starts a test phase.
// - Device clears F800 bit 0 when phase ends.
// - After phase two, status bit 12 flags match.
// - F800 bit 15 opens data RAM test access.
// - Data RAM test reads allowed in any order.
// - Channel in top digit; Q even, I odd.
// - Locations 0 and 1 load holding halves.
// - Location 2 write strobes holding into target.
// - Location 3 selects read source, strobing reads.
// - Indirect transfer takes four clocks.
//
// Constants for the downconverter test and configuration block.
// Included by the design files; holds definitions only.
`ifndef DSTS_DEFS_VH
`define DSTS_DEFS_VH

// Direct port locations
`define DSTS_LOC_LOW        3'h0
`define DSTS_LOC_HIGH       3'h1
`define DSTS_LOC_WTARGET    3'h2
`define DSTS_LOC_RSELECT    3'h3

// Global write space addresses
`define DSTS_GWA_CTRL       16'hF800
`define DSTS_GWA_SYNC_OUT   16'hF809
`define DSTS_GWA_SYNC_BOTH  16'hF80A
`define DSTS_GWA_SIG        16'hF80B
`define DSTS_GWA_RST_ALL    16'hF019

// Channel write space offsets (low three digits)
`define DSTS_CH_ENGINE      12'h00A
`define DSTS_CH_SWRST       12'h019

// Field positions
`define DSTS_HOLD_BIT       31
`define DSTS_START_BIT      0
`define DSTS_RAMTEST_BIT    15
`define DSTS_MATCH_BIT      12
`define DSTS_SYNCIN_BIT     6

// Reset values
`define DSTS_CTRL_RST       32'h0000_0000
`define DSTS_SIG_RST        16'h0000
`define DSTS_SIG_SEED       16'hFFFF

// Timing counts in clocks
`define DSTS_XFER_CLKS      4
`define DSTS_ENG_RST_CLKS   32

`endif

// ===== logic/dsts_sig_gen.v
// Pseudo-random stimulus and output signature register for self test.
// Assumes the caller clears it at a test start and gates it with i_run.
`timescale 1ns/1ps
`include "dsts_defs.vh"

module dsts_sig_gen #(
  parameter WIDTH = 16
) (
  input  wire             i_mclk,
  input  wire             i_sys_rst,
  input  wire             i_clear,
  input  wire             i_run,
  input  wire             i_valid,
  input  wire [WIDTH-1:0] i_data,
  output reg  [WIDTH-1:0] o_pn,
  output reg  [WIDTH-1:0] o_sig
);

  wire pn_fb;
  wire sig_fb;

  // Taps 16,15,13,4 give a maximal sequence
  assign pn_fb  = o_pn[WIDTH-1] ^ o_pn[WIDTH-2] ^ o_pn[WIDTH-4] ^ o_pn[3];
  assign sig_fb = o_sig[WIDTH-1] ^ o_sig[WIDTH-2] ^ o_sig[WIDTH-4] ^ o_sig[3];

  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_pn  <= `DSTS_SIG_SEED;
      o_sig <= `DSTS_SIG_RST;
    end else if (i_clear) begin
      o_pn  <= `DSTS_SIG_SEED;
      o_sig <= `DSTS_SIG_RST;
    end else if (i_run) begin
      o_pn <= {o_pn[WIDTH-2:0], pn_fb};
      if (i_valid) begin
        o_sig <= {o_sig[WIDTH-2:0], sig_fb} ^ i_data; // Multiple-input compaction
      end
    end
  end

endmodule // dsts_sig_gen

// ===== testbench/dsts_top_props.sv
// Port checker for dsts_top.
// Assumes a bind to dsts_top with the same BUILT_IN_SELF_TEST_CLKS.
`timescale 1ns/1ps
module dsts_top_props #(
  parameter BUILT_IN_SELF_TEST_CLKS = 4096
) (
  input wire       i_mclk,
  input wire       i_sys_rst,
  input wire       i_rd_n,
  input wire       o_p_oe_n,
  input wire       o_iw_strobe,
  input wire       o_ir_strobe,
  input wire [3:0] o_compute_hold,
  input wire [3:0] o_engine_reset,
  input wire [3:0] o_chan_sw_reset,
  input wire       o_sync_pulse_output,
  input wire       o_int_sync,
  input wire       o_built_in_self_test_active
);
  reg [6:0]  eng_cnt;
  reg [15:0] built_in_self_test_cnt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  // Run lengths of engine reset on channel 2 and of a test phase
  always @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      eng_cnt  <= 7'h00;
      built_in_self_test_cnt <= 16'h0000;
    end else begin
      eng_cnt  <= o_engine_reset[2] ? eng_cnt + 7'h01 : 7'h00;
      built_in_self_test_cnt <= o_built_in_self_test_active ? built_in_self_test_cnt + 16'h0001 : 16'h0000;
    end
  end
  a_iw_strobe_pulse: assert property (o_iw_strobe |=> !o_iw_strobe)
    else $error("write strobe too long");
  a_ir_strobe_pulse: assert property (o_ir_strobe |=> !o_ir_strobe)
    else $error("read strobe too long");
  a_read_drive_cause: assert property (!o_p_oe_n |-> !($past(i_rd_n, 2) && $past(i_rd_n, 3)))
    else $error("bus driven without read");
  a_engine_rst_start: assert property ($fell(o_compute_hold[2]) |-> ##[1:3] o_engine_reset[2])
    else $error("engine reset missing");
  a_engine_rst_len: assert property ($fell(o_engine_reset[2]) |-> eng_cnt == 7'h20)
    else $error("engine reset length wrong");
  a_sync_both_pair: assert property (o_int_sync |-> o_sync_pulse_output)
    else $error("input sync without output sync");
  a_chan_rst_pulse: assert property (|o_chan_sw_reset |=> o_chan_sw_reset == 4'h0)
    else $error("channel reset too long");
  a_built_in_self_test_phase_end: assert property ($fell(o_built_in_self_test_active) |-> built_in_self_test_cnt >= BUILT_IN_SELF_TEST_CLKS - 1)
    else $error("test phase ended early");
  a_built_in_self_test_phase_cap: assert property (o_built_in_self_test_active |-> built_in_self_test_cnt <= BUILT_IN_SELF_TEST_CLKS + 1)
    else $error("test phase overran");
  c_write: cover property (o_iw_strobe);
  c_sync: cover property (o_int_sync);
  c_built_in_self_test: cover property ($fell(o_built_in_self_test_active));
endmodule // dsts_top_props

bind dsts_top dsts_top_props #(.BUILT_IN_SELF_TEST_CLKS(BUILT_IN_SELF_TEST_CLKS)) dsts_top_props_inst (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_rd_n(i_rd_n), .o_p_oe_n(o_p_oe_n),
  .o_iw_strobe(o_iw_strobe), .o_ir_strobe(o_ir_strobe), .o_compute_hold(o_compute_hold),
  .o_engine_reset(o_engine_reset), .o_chan_sw_reset(o_chan_sw_reset),
  .o_sync_pulse_output(o_sync_pulse_output), .o_int_sync(o_int_sync), .o_built_in_self_test_active(o_built_in_self_test_active));

// ===== testbench/dsts_host_model.sv
// Host processor on the 16-bit direct port.
// Assumes the caller gives it the device clock and read data.
`timescale 1ns/1ps
module dsts_host_model (
  input  wire        i_mclk,
  input  wire [15:0] i_p,
  input  wire        i_p_oe_n,
  output reg         o_ce_n,
  output reg         o_wr_n,
  output reg         o_rd_n,
  output reg  [2:0]  o_add,
  output reg  [15:0] o_p
);
  // Idle pins at time zero
  initial begin
    o_ce_n = 1'b1;
    o_wr_n = 1'b1;
    o_rd_n = 1'b1;
    o_add  = 3'h0;
    o_p    = 16'h0000;
  end
  // Direct write; pins held well past the synchronised edge
  task bus_wr(input [2:0] loc, input [15:0] d);
    begin
      @(posedge i_mclk);
      o_ce_n <= 1'b0;
      o_add  <= loc;
      o_p    <= d;
      o_wr_n <= 1'b0;
      repeat (4) @(posedge i_mclk);
      o_wr_n <= 1'b1;
      repeat (4) @(posedge i_mclk);
      o_ce_n <= 1'b1;
      o_p    <= ~d; // Released data shows no stale value
    end
  endtask
  // Direct read; undriven bus reads as unknown
  task bus_rd(input [2:0] loc, output [15:0] d);
    begin
      @(posedge i_mclk);
      o_ce_n <= 1'b0;
      o_add  <= loc;
      o_rd_n <= 1'b0;
      repeat (6) @(posedge i_mclk);
      d = i_p_oe_n ? 16'hXXXX : i_p;
      o_rd_n <= 1'b1;
      o_ce_n <= 1'b1;
    end
  endtask
  // Indirect write through the holding register
  task ind_wr(input [15:0] a, input [31:0] d);
    begin
      bus_wr(3'h0, d[15:0]);
      bus_wr(3'h1, d[31:16]);
      bus_wr(3'h2, a);
      repeat (4) @(posedge i_mclk);
    end
  endtask
  // Indirect read: select source, then both halves
  task ind_rd(input [15:0] a, output [31:0] d);
    reg [15:0] lo;
    reg [15:0] hi;
    begin
      bus_wr(3'h3, a);
      repeat (4) @(posedge i_mclk);
      bus_rd(3'h0, lo);
      bus_rd(3'h1, hi);
      d = {hi, lo};
    end
  endtask
endmodule // dsts_host_model

// ===== testbench/dsts_top_tb.sv
// Self-checking bench for dsts_top.
// Assumes a datapath that echoes the test stimulus back.
`timescale 1ns/1ps
module dsts_top_tb;
  reg         i_mclk;
  reg         i_sys_rst = 1'b1;
  reg         sync_in = 1'b0;
  reg  [31:0] ir_data = 32'h5A3C_0F96;
  wire        ce_n, wr_n, rd_n, oe_n, iw_stb, ir_stb, sync_o, int_sync, built_in_self_test, ram_test;
  wire [2:0]  add;
  wire [15:0] host_p, p_in, p_out, iw_addr, ir_addr, pn;
  wire [31:0] iw_data;
  wire [3:0]  hold, eng_rst, ch_rst;
  integer     n_fail = 0, samples_checked = 0, cyc = 0, n_iw = 0, n_so = 0, n_is = 0;
  reg  [3:0]  rst_seen = 4'h0;
  reg  [31:0] rd, s1, s2;
  reg  [15:0] st;

  // Clock source
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // Bus level seen by the device; the host reads p_out directly
  assign p_in = oe_n ? host_p : p_out;
  dsts_host_model dsts_host_model_inst (.i_mclk(i_mclk), .i_p(p_out), .i_p_oe_n(oe_n), .o_ce_n(ce_n),
    .o_wr_n(wr_n), .o_rd_n(rd_n), .o_add(add), .o_p(host_p));
  dsts_top #(.BUILT_IN_SELF_TEST_CLKS(16)) dsts_top_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce_n(ce_n),
    .i_wr_n(wr_n), .i_rd_n(rd_n), .i_add(add), .i_p(p_in), .o_p(p_out), .o_p_oe_n(oe_n),
    .i_external_sync_input(sync_in), .o_iw_strobe(iw_stb), .o_iw_addr(iw_addr), .o_iw_data(iw_data),
    .o_ir_strobe(ir_stb), .o_ir_addr(ir_addr), .i_ir_data(ir_data), .o_compute_hold(hold),
    .o_engine_reset(eng_rst), .o_chan_sw_reset(ch_rst), .o_sync_pulse_output(sync_o),
    .o_int_sync(int_sync), .o_built_in_self_test_active(built_in_self_test), .o_pn_data(pn), .i_out_valid(built_in_self_test),
    .i_out_data(pn), .o_ram_test(ram_test));
  // Pulse counters and hang limit
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    n_iw <= n_iw + iw_stb;
    n_so <= n_so + sync_o;
    n_is <= n_is + int_sync;
    rst_seen <= rst_seen | ch_rst;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Forwarded writes back to back, then an external read
  task t_xfer;
    begin
      dsts_host_model_inst.ind_wr(16'h1005, 32'h89AB_CDEF);
      chk(iw_addr, 16'h1005);
      chk(iw_data, 32'h89AB_CDEF);
      dsts_host_model_inst.ind_wr(16'h1006, 32'h0000_1234);
      chk(n_iw, 2);
      dsts_host_model_inst.ind_rd(16'h0010, rd);
      chk(ir_addr, 16'h0010);
      chk(rd, 32'h5A3C_0F96);
    end
  endtask
  // Reconfigure channel 2, then channel and global resets
  task t_hold;
    begin
      dsts_host_model_inst.ind_wr(16'hF801, 32'h0000_0000);
      dsts_host_model_inst.ind_wr(16'hF802, 32'h0000_0000);
      dsts_host_model_inst.ind_wr(16'h200A, 32'h8000_0000);
      chk(hold, 4'h4);
      dsts_host_model_inst.ind_wr(16'h200A, 32'h0000_0000);
      chk(eng_rst, 4'h4);
      repeat (32) @(posedge i_mclk);
      chk(eng_rst, 4'h0);
      // Clear off the edge so the pulse collector cannot race it
      @(negedge i_mclk) rst_seen = 4'h0;
      dsts_host_model_inst.ind_wr(16'h2019, 32'h0000_0000);
      chk(rst_seen, 4'h4);
      @(negedge i_mclk) rst_seen = 4'h0;
      dsts_host_model_inst.ind_wr(16'hF019, 32'h0000_0001);
      chk(rst_seen, 4'h0);
      dsts_host_model_inst.ind_wr(16'hF019, 32'h0000_0000);
      chk(rst_seen, 4'hF);
      dsts_host_model_inst.ind_wr(16'hF80A, 32'h0000_0000);
      dsts_host_model_inst.ind_wr(16'hF809, 32'h0000_0000);
      chk(n_so, 2);
      chk(n_is, 1);
      // sync pin level shown in status
      @(posedge i_mclk) sync_in <= 1'b1;
      dsts_host_model_inst.bus_rd(3'h3, st);
      chk(st[6], 1'b1);
    end
  endtask
  // Two test phases with a given expected signature
  task run_built_in_self_test(input [15:0] exp, output [31:0] s);
    integer k;
    begin
      dsts_host_model_inst.ind_wr(16'hF80B, {16'h0000, exp});
      repeat (2) begin
        dsts_host_model_inst.ind_wr(16'hF019, 32'h0000_0000);
        dsts_host_model_inst.ind_wr(16'hF800, 32'h0000_0001);
        chk(built_in_self_test, 1'b1);
        rd = 32'h1;
        for (k = 0; k < 8 && rd[0] !== 1'b0; k = k + 1)
          dsts_host_model_inst.ind_rd(16'hF800, rd);
        chk(rd[0], 1'b0);
      end
      dsts_host_model_inst.ind_rd(16'hF80B, s);
      dsts_host_model_inst.bus_rd(3'h3, st);
    end
  endtask
  // Self test: readback, repeatability, match and mismatch
  task t_built_in_self_test;
    begin
      run_built_in_self_test(16'h0001, s1);
      chk(s1[15:0], 16'h0001);
      run_built_in_self_test(s1[31:16], s2);
      chk(s2, {s1[31:16], s1[31:16]});
      chk(st[12], 1'b1);
      dsts_host_model_inst.ind_rd(16'hF80B, rd);
      chk(rd, s2);
      run_built_in_self_test(~s1[31:16], s2);
      chk(st[12], 1'b0);
    end
  endtask
  // Data RAM test: pair write, reverse reads, unused offset
  task t_ram;
    begin
      dsts_host_model_inst.ind_wr(16'hF800, 32'h0000_8000);
      chk(ram_test, 1'b1);
      dsts_host_model_inst.ind_wr(16'h36FE, 32'h00AB_CDEF);
      dsts_host_model_inst.ind_wr(16'h36FF, 32'h0012_3456);
      // same offsets on channel 1 must not alias
      dsts_host_model_inst.ind_wr(16'h16FE, 32'h0055_5555);
      dsts_host_model_inst.ind_wr(16'h16FF, 32'h0066_6666);
      chk(n_iw, 2);
      dsts_host_model_inst.ind_wr(16'h3300, 32'h0077_7777);
      chk(n_iw, 3);
      dsts_host_model_inst.ind_rd(16'h36FF, rd);
      chk(rd[23:0], 24'h12_3456);
      dsts_host_model_inst.ind_rd(16'h36FE, rd);
      chk(rd[23:0], 24'hAB_CDEF);
      dsts_host_model_inst.ind_rd(16'h16FE, rd);
      chk(rd[23:0], 24'h55_5555);
      dsts_host_model_inst.ind_wr(16'hF800, 32'h0000_0000);
      chk(ram_test, 1'b0);
    end
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({oe_n, ram_test, built_in_self_test, hold, pn}, {3'h4, 4'h0, 16'hFFFF});
    t_xfer;
    t_ram;
    t_hold;
    t_built_in_self_test;
    print_verdict;
  end
endmodule // dsts_top_tb
